// File: fbr_regs.sv
// How it works
// - swap with bit 0 clear is immediate; bit 0 set waits for retrace
// - pending count rises on accepting a swap, falls on each real swap
// - retrace counter must exceed interval bits 8:1; cleared on each swap
// - unsynchronised swaps ignore the interval and count no retraces
// - fog colour register bytes blue, green, red feed fog when enabled
// - rectangle clear writes constant depth bits 15:0
// - depth bias enabled takes bias depth from bits 15:0
// - linear writes lacking alpha or depth use constant alpha and depth
// - chroma keying enabled blocks colour writes of pixels matching key colour; their depth is still written
// - key match compares red, green, blue only, never alpha
// - key test sits after texture lookup, before lighting and fog
// - key register is 24-bit rgb, upper byte reserved
// - 32-bit stipple mask gates colour and depth writes per pixel
// - first constant colour feeds local colour and local alpha
// - second constant colour feeds other colour and alpha by path bits
// - rectangle clear fills colour from second constant colour 23:0
// - depth-only format 15 with pipeline on takes second constant colour
// - processed pixel counter counts every walker pixel
// - key fail counter counts key-matched dropped pixels
// - depth fail counter counts depth-test failures
// - counters clear at reset and on flush write with bit 0 set
// - flush write with bit 0 clear leaves counters alone
`timescale 1ns/1ns
module fbr_regs
  import fbr_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  output logic reg_rd_valid,
  input wire logic vretrace_pulse,
  input wire logic fog_en,
  input wire logic chroma_en,
  input wire logic depth_bias_en,
  input wire logic [3:0] colour_path_sel,
  input wire logic lfb_pipe_en,
  input wire logic [3:0] lfb_format,
  input wire logic walk_pixel,
  input wire logic tex_valid,
  input wire logic [23:0] tex_rgb,
  input wire logic [7:0] tex_alpha,
  input wire logic [4:0] tex_stipple_idx,
  input wire logic depth_fail,
  output logic swap_now,
  output logic [2:0] swaps_pending,
  output logic [23:0] fog_colour_out,
  output logic [23:0] local_colour,
  output logic [7:0] local_alpha,
  output logic [23:0] other_colour,
  output logic other_colour_sel,
  output logic [7:0] other_alpha,
  output logic other_alpha_sel,
  output logic [23:0] fill_colour,
  output logic [15:0] fill_depth,
  output logic [15:0] bias_depth,
  output logic [7:0] lfb_alpha,
  output logic [15:0] lfb_depth,
  output logic [23:0] lfb_colour,
  output logic lfb_colour_sel,
  output logic px_valid,
  output logic [23:0] px_rgb,
  output logic [7:0] px_alpha,
  output logic px_key_drop,
  output logic px_colour_wr,
  output logic px_depth_wr
);

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic wr_hit(input logic en, input logic [7:0] a, input logic [7:0] idx);
    wr_hit = en && (a == idx);
  endfunction : wr_hit

  // wraps at the top; clear beats a same-cycle increment
  function automatic logic [23:0] cnt_next(input logic [23:0] c, input logic inc,
                                            input logic clr);
    if (clr)
      cnt_next = CNT_RST;
    else if (inc)
      cnt_next = c + 24'h00_0001;
    else
      cnt_next = c;
  endfunction : cnt_next

  // ****************************************************************
  // host registers
  // ****************************************************************
  logic [31:0] fog_r, fog_nxt;
  logic [31:0] za_r, za_nxt;
  logic [31:0] key_r, key_nxt;
  logic [31:0] stip_r, stip_nxt;
  logic [31:0] c0_r, c0_nxt;
  logic [31:0] c1_r, c1_nxt;
  logic flush_clr;

  // plain stores; reserved key byte is dropped on write
  always_comb
  begin
    fog_nxt = wr_hit(reg_wr_en, reg_addr, IDX_FOG) ? reg_wdata : fog_r;
    za_nxt = wr_hit(reg_wr_en, reg_addr, IDX_ZA) ? reg_wdata : za_r;
    key_nxt = key_r;
    if (wr_hit(reg_wr_en, reg_addr, IDX_KEY))
      key_nxt = {8'h00, reg_wdata[RGB_MSB:0]};
    stip_nxt = wr_hit(reg_wr_en, reg_addr, IDX_STIP) ? reg_wdata : stip_r;
    c0_nxt = wr_hit(reg_wr_en, reg_addr, IDX_C0) ? reg_wdata : c0_r;
    c1_nxt = wr_hit(reg_wr_en, reg_addr, IDX_C1) ? reg_wdata : c1_r;
    flush_clr = wr_hit(reg_wr_en, reg_addr, IDX_FLUSH) && reg_wdata[FLUSH_CLR_BIT];
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      fog_r <= REG_RST;
      za_r <= REG_RST;
      key_r <= REG_RST;
      stip_r <= REG_RST;
      c0_r <= REG_RST;
      c1_r <= REG_RST;
    end
    else
    begin
      fog_r <= fog_nxt;
      za_r <= za_nxt;
      key_r <= key_nxt;
      stip_r <= stip_nxt;
      c0_r <= c0_nxt;
      c1_r <= c1_nxt;
    end
  end

  // ****************************************************************
  // swap command queue and retrace pacing
  // ****************************************************************
  logic [8:0] swap_q_r [0:SWAP_Q_DEPTH-1];
  logic [2:0] wr_ptr_r, wr_ptr_nxt, rd_ptr_r, rd_ptr_nxt;
  logic [2:0] pend_r, pend_nxt;
  logic [8:0] rc_r, rc_nxt, rc_inc;
  fbr_swap_e swp_r, swp_nxt;
  logic swap_r, swap_nxt;
  logic push, pop, hit;
  logic [8:0] head;

  // the queue stands in for swap commands still sitting in the host fifo
  always_comb
  begin
    head = swap_q_r[rd_ptr_r];
    rc_inc = (rc_r == RC_MAX) ? rc_r : rc_r + 9'h001; // saturate, never alias
    hit = rc_inc > {1'b0, head[SWAP_IVL_MSB:SWAP_IVL_LSB]};
    pop = 1'b0;
    swp_nxt = swp_r;
    case (swp_r)
      SWP_IDLE:
      begin
        if (pend_r != PEND_RST)
        begin
          if (!head[SWAP_SYNC_BIT])
            pop = 1'b1;
          else
            swp_nxt = SWP_WAIT;
        end
      end
      SWP_WAIT:
      begin
        if (vretrace_pulse && hit)
        begin
          pop = 1'b1;
          swp_nxt = SWP_IDLE;
        end
      end
      default: swp_nxt = SWP_IDLE;
    endcase
    // a full queue refuses a new command unless one leaves this cycle
    push = wr_hit(reg_wr_en, reg_addr, IDX_SWAP) && (pend_r != PEND_MAX || pop);
    wr_ptr_nxt = push ? wr_ptr_r + 3'h1 : wr_ptr_r;
    rd_ptr_nxt = pop ? rd_ptr_r + 3'h1 : rd_ptr_r;
    pend_nxt = pend_r;
    if (push && !pop)
      pend_nxt = pend_r + 3'h1;
    else if (pop && !push)
      pend_nxt = pend_r - 3'h1;
    rc_nxt = rc_r;
    if (pop)
      rc_nxt = RC_RST;
    else if (vretrace_pulse)
      rc_nxt = rc_inc;
    swap_nxt = pop;
  end

  always_ff @(posedge core_clk)
  begin
    if (push)
      swap_q_r[wr_ptr_r] <= reg_wdata[SWAP_IVL_MSB:0];
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      wr_ptr_r <= PEND_RST;
      rd_ptr_r <= PEND_RST;
      pend_r <= PEND_RST;
      rc_r <= RC_RST;
      swp_r <= SWP_IDLE;
      swap_r <= 1'b0;
    end
    else
    begin
      wr_ptr_r <= wr_ptr_nxt;
      rd_ptr_r <= rd_ptr_nxt;
      pend_r <= pend_nxt;
      rc_r <= rc_nxt;
      swp_r <= swp_nxt;
      swap_r <= swap_nxt;
    end
  end

  assign swap_now = swap_r;
  assign swaps_pending = pend_r;

  // ****************************************************************
  // constant feeds to combine, fog, clear and linear write paths
  // ****************************************************************
  logic [23:0] fogc_r, fogc_nxt, lc_r, lc_nxt, oc_r, oc_nxt, fc_r, fc_nxt, lfc_r, lfc_nxt;
  logic [7:0] la_r, la_nxt, oa_r, oa_nxt, lfa_r, lfa_nxt;
  logic [15:0] fd_r, fd_nxt, bd_r, bd_nxt, lfd_r, lfd_nxt;
  logic ocs_r, ocs_nxt, oas_r, oas_nxt, lfs_r, lfs_nxt;

  // registered so every output leaves from a flop; costs one cycle after a write
  always_comb
  begin
    fogc_nxt = fog_en ? fog_r[RGB_MSB:0] : 24'h00_0000;
    lc_nxt = c0_r[RGB_MSB:0];
    la_nxt = c0_r[ALPHA_MSB:ALPHA_LSB];
    oc_nxt = c1_r[RGB_MSB:0];
    ocs_nxt = colour_path_sel[1:0] == OTHER_SEL_C1;
    oa_nxt = c1_r[ALPHA_MSB:ALPHA_LSB];
    oas_nxt = colour_path_sel[3:2] == OTHER_SEL_C1;
    fc_nxt = c1_r[RGB_MSB:0];
    fd_nxt = za_r[DEPTH_MSB:0];
    bd_nxt = depth_bias_en ? za_r[DEPTH_MSB:0] : 16'h0000;
    lfa_nxt = za_r[ALPHA_MSB:ALPHA_LSB];
    lfd_nxt = za_r[DEPTH_MSB:0];
    lfc_nxt = c1_r[RGB_MSB:0];
    lfs_nxt = lfb_pipe_en && (lfb_format == LFB_FMT_DEPTH_ONLY);
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      fogc_r <= 24'h00_0000;
      lc_r <= 24'h00_0000;
      la_r <= 8'h00;
      oc_r <= 24'h00_0000;
      ocs_r <= 1'b0;
      oa_r <= 8'h00;
      oas_r <= 1'b0;
      fc_r <= 24'h00_0000;
      fd_r <= 16'h0000;
      bd_r <= 16'h0000;
      lfa_r <= 8'h00;
      lfd_r <= 16'h0000;
      lfc_r <= 24'h00_0000;
      lfs_r <= 1'b0;
    end
    else
    begin
      fogc_r <= fogc_nxt;
      lc_r <= lc_nxt;
      la_r <= la_nxt;
      oc_r <= oc_nxt;
      ocs_r <= ocs_nxt;
      oa_r <= oa_nxt;
      oas_r <= oas_nxt;
      fc_r <= fc_nxt;
      fd_r <= fd_nxt;
      bd_r <= bd_nxt;
      lfa_r <= lfa_nxt;
      lfd_r <= lfd_nxt;
      lfc_r <= lfc_nxt;
      lfs_r <= lfs_nxt;
    end
  end

  assign fog_colour_out = fogc_r;
  assign local_colour = lc_r;
  assign local_alpha = la_r;
  assign other_colour = oc_r;
  assign other_colour_sel = ocs_r;
  assign other_alpha = oa_r;
  assign other_alpha_sel = oas_r;
  assign fill_colour = fc_r;
  assign fill_depth = fd_r;
  assign bias_depth = bd_r;
  assign lfb_alpha = lfa_r;
  assign lfb_depth = lfd_r;
  assign lfb_colour = lfc_r;
  assign lfb_colour_sel = lfs_r;

  // ****************************************************************
  // key test stage: fed from texture lookup, drives lighting and fog
  // ****************************************************************
  logic pv_r, pv_nxt, pk_r, pk_nxt, pcw_r, pcw_nxt, pdw_r, pdw_nxt;
  logic [23:0] prgb_r, prgb_nxt;
  logic [7:0] pa_r, pa_nxt;
  logic key_match, stip_ok;

  // alpha never enters the compare
  always_comb
  begin
    key_match = tex_valid && chroma_en && (tex_rgb == key_r[RGB_MSB:0]);
    stip_ok = stip_r[tex_stipple_idx];
    pv_nxt = tex_valid;
    prgb_nxt = tex_rgb;
    pa_nxt = tex_alpha;
    pk_nxt = key_match;
    pcw_nxt = tex_valid && stip_ok && !key_match;
    pdw_nxt = tex_valid && stip_ok;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      pv_r <= 1'b0;
      prgb_r <= 24'h00_0000;
      pa_r <= 8'h00;
      pk_r <= 1'b0;
      pcw_r <= 1'b0;
      pdw_r <= 1'b0;
    end
    else
    begin
      pv_r <= pv_nxt;
      prgb_r <= prgb_nxt;
      pa_r <= pa_nxt;
      pk_r <= pk_nxt;
      pcw_r <= pcw_nxt;
      pdw_r <= pdw_nxt;
    end
  end

  assign px_valid = pv_r;
  assign px_rgb = prgb_r;
  assign px_alpha = pa_r;
  assign px_key_drop = pk_r;
  assign px_colour_wr = pcw_r;
  assign px_depth_wr = pdw_r;

  // ****************************************************************
  // statistics counters and read port
  // ****************************************************************
  logic [23:0] pin_r, pin_nxt, kf_r, kf_nxt, zf_r, zf_nxt;
  logic [31:0] rd_r, rd_nxt;
  logic rv_r, rv_nxt;

  always_comb
  begin
    pin_nxt = cnt_next(pin_r, walk_pixel, flush_clr);
    kf_nxt = cnt_next(kf_r, key_match, flush_clr);
    zf_nxt = cnt_next(zf_r, depth_fail, flush_clr);
    rv_nxt = reg_rd_en;
    rd_nxt = 32'h0000_0000;
    if (reg_rd_en)
    begin
      case (reg_addr)
        IDX_STATUS: rd_nxt[STAT_PEND_LSB+2:STAT_PEND_LSB] = pend_r;
        IDX_FOG: rd_nxt = fog_r;
        IDX_ZA: rd_nxt = za_r;
        IDX_KEY: rd_nxt = key_r;
        IDX_STIP: rd_nxt = stip_r;
        IDX_C0: rd_nxt = c0_r;
        IDX_C1: rd_nxt = c1_r;
        IDX_PIXIN: rd_nxt = {8'h00, pin_r};
        IDX_KEYF: rd_nxt = {8'h00, kf_r};
        IDX_ZF: rd_nxt = {8'h00, zf_r};
        default: rd_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      pin_r <= CNT_RST;
      kf_r <= CNT_RST;
      zf_r <= CNT_RST;
      rd_r <= REG_RST;
      rv_r <= 1'b0;
    end
    else
    begin
      pin_r <= pin_nxt;
      kf_r <= kf_nxt;
      zf_r <= zf_nxt;
      rd_r <= rd_nxt;
      rv_r <= rv_nxt;
    end
  end

  assign reg_rdata = rd_r;
  assign reg_rd_valid = rv_r;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_nosync_head;
    swp_r == SWP_IDLE && pend_r != PEND_RST && !head[SWAP_SYNC_BIT];
  endsequence
  sequence s_retrace_hit;
    swp_r == SWP_WAIT && vretrace_pulse && hit;
  endsequence

  property p_nosync_swap;
    s_nosync_head |=> swap_now && rc_r == RC_RST;
  endproperty
  a_nosync_swap: assert property (p_nosync_swap) else $error("unsynced swap late");

  property p_wait_retrace;
    (swp_r == SWP_WAIT && !vretrace_pulse) |=> !swap_now ##0 swp_r == SWP_WAIT;
  endproperty
  a_wait_retrace: assert property (p_wait_retrace) else $error("swap without retrace");

  property p_retrace_swap;
    s_retrace_hit |=> swap_now && swp_r == SWP_IDLE && rc_r == RC_RST;
  endproperty
  a_retrace_swap: assert property (p_retrace_swap) else $error("retrace swap missed");

  property p_interval_hold;
    (swp_r == SWP_WAIT && vretrace_pulse && !hit) |=> !swap_now;
  endproperty
  a_interval_hold: assert property (p_interval_hold) else $error("interval ignored");

  property p_pend_up;
    (wr_hit(reg_wr_en, reg_addr, IDX_SWAP) && pend_r != PEND_MAX && !pop)
      |=> pend_r == $past(pend_r) + 3'h1;
  endproperty
  a_pend_up: assert property (p_pend_up) else $error("pending not raised");

  property p_pend_down;
    swap_nxt && !push |=> pend_r == $past(pend_r) - 3'h1;
  endproperty
  a_pend_down: assert property (p_pend_down) else $error("pending not lowered");

  property p_key_drop;
    (tex_valid && chroma_en && tex_rgb == key_r[RGB_MSB:0]) |=> px_key_drop && !px_colour_wr;
  endproperty
  a_key_drop: assert property (p_key_drop) else $error("key pixel written");

  property p_key_count;
    (key_match && !flush_clr) |=> kf_r == $past(kf_r) + 24'h00_0001;
  endproperty
  a_key_count: assert property (p_key_count) else $error("key fail not counted");

  property p_stipple;
    (tex_valid && !stip_r[tex_stipple_idx]) |=> !px_colour_wr && !px_depth_wr;
  endproperty
  a_stipple: assert property (p_stipple) else $error("stipple ignored");

  property p_flush_clear;
    flush_clr |=> pin_r == CNT_RST && kf_r == CNT_RST && zf_r == CNT_RST;
  endproperty
  a_flush_clear: assert property (p_flush_clear) else $error("counters not cleared");

  property p_flush_keep;
    (wr_hit(reg_wr_en, reg_addr, IDX_FLUSH) && !reg_wdata[FLUSH_CLR_BIT] && !walk_pixel)
      |=> pin_r == $past(pin_r);
  endproperty
  a_flush_keep: assert property (p_flush_keep) else $error("counter changed by flush");

endmodule : fbr_regs

// File: fbr_pkg.sv
package fbr_pkg;

  // ****************************************************************
  // register indices on the host write/read port
  // ****************************************************************
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] IDX_STATUS = 8'h00;
  localparam logic [7:0] IDX_SWAP = 8'h01;
  localparam logic [7:0] IDX_FLUSH = 8'h02;
  localparam logic [7:0] IDX_FOG = 8'h03;
  localparam logic [7:0] IDX_ZA = 8'h04;
  localparam logic [7:0] IDX_KEY = 8'h05;
  localparam logic [7:0] IDX_STIP = 8'h06;
  localparam logic [7:0] IDX_C0 = 8'h07;
  localparam logic [7:0] IDX_C1 = 8'h08;
  localparam logic [7:0] IDX_PIXIN = 8'h09;
  localparam logic [7:0] IDX_KEYF = 8'h0a;
  localparam logic [7:0] IDX_ZF = 8'h0b;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int unsigned SWAP_SYNC_BIT = 0;
  localparam int unsigned SWAP_IVL_LSB = 1;
  localparam int unsigned SWAP_IVL_MSB = 8;
  localparam int unsigned STAT_PEND_LSB = 28;
  localparam int unsigned FLUSH_CLR_BIT = 0;
  localparam int unsigned RGB_MSB = 23;
  localparam int unsigned DEPTH_MSB = 15;
  localparam int unsigned ALPHA_LSB = 24;
  localparam int unsigned ALPHA_MSB = 31;

  // ****************************************************************
  // reset values and limits
  // ****************************************************************
  localparam logic [31:0] REG_RST = 32'h0000_0000;
  localparam logic [23:0] CNT_RST = 24'h00_0000;
  localparam logic [8:0] RC_RST = 9'h000;
  localparam logic [8:0] RC_MAX = 9'h1ff;
  localparam logic [2:0] PEND_RST = 3'h0;
  localparam logic [2:0] PEND_MAX = 3'h7;
  localparam int unsigned SWAP_Q_DEPTH = 8;

  // ****************************************************************
  // selector encodings
  // ****************************************************************
  localparam logic [1:0] OTHER_SEL_C1 = 2'h2;
  localparam logic [3:0] LFB_FMT_DEPTH_ONLY = 4'hf;

  typedef enum logic [0:0] {SWP_IDLE, SWP_WAIT} fbr_swap_e;

endpackage : fbr_pkg

// File: fbr_host.sv
`timescale 1ns/1ns
module fbr_host
  import fbr_pkg::*;
(
  input wire logic core_clk,
  output logic reg_wr_en,
  output logic reg_rd_en,
  output logic [ADDR_W-1:0] reg_addr,
  output logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata,
  input wire logic reg_rd_valid
);
  // ********
  // host side of the register port
  // ********

  // idle until the first call
  initial
  begin
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
  end

  // held up to the taking edge, then inverted so stale values never pass
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    #1;
    reg_wr_en = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge core_clk);
    #1;
    reg_wr_en = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask : wr

  // answer registered at the taking edge, picked up just after it
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic v);
    @(posedge core_clk);
    #1;
    reg_rd_en = 1'b1;
    reg_addr = a;
    @(posedge core_clk);
    #1;
    d = reg_rdata;
    v = reg_rd_valid;
    reg_rd_en = 1'b0;
    reg_addr = ~a;
  endtask : rd

  // triple buffering only works with sync on and interval zero
  task automatic swap_triple();
    wr(IDX_SWAP, 32'h0000_0001);
  endtask : swap_triple
endmodule : fbr_host

// File: fbr_regs_test.sv
`timescale 1ns/1ns
module fbr_regs_test
  import fbr_pkg::*;
();
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic reg_wr_en, reg_rd_en, reg_rd_valid, vretrace_pulse, fog_en, chroma_en;
  logic depth_bias_en, lfb_pipe_en, walk_pixel, tex_valid, depth_fail, swap_now;
  logic other_colour_sel, other_alpha_sel, lfb_colour_sel, px_valid, px_key_drop;
  logic px_colour_wr, px_depth_wr, rd_v, seen;
  logic [ADDR_W-1:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rd_d;
  logic [3:0] colour_path_sel, lfb_format;
  logic [4:0] tex_stipple_idx;
  logic [2:0] swaps_pending;
  logic [7:0] tex_alpha, local_alpha, other_alpha, lfb_alpha, px_alpha;
  logic [15:0] fill_depth, bias_depth, lfb_depth;
  logic [23:0] tex_rgb, fog_colour_out, local_colour, other_colour, fill_colour;
  logic [23:0] lfb_colour, px_rgb;
  int n_fail = 0;
  int samples_checked = 0;

  // 125 MHz
  always #4 core_clk = ~core_clk;

  fbr_host fbr_host_i (.core_clk(core_clk), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rd_valid(reg_rd_valid));

  fbr_regs fbr_regs_i (.core_clk(core_clk), .rst(rst), .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid), .vretrace_pulse(vretrace_pulse),
    .fog_en(fog_en), .chroma_en(chroma_en), .depth_bias_en(depth_bias_en),
    .colour_path_sel(colour_path_sel), .lfb_pipe_en(lfb_pipe_en), .lfb_format(lfb_format),
    .walk_pixel(walk_pixel), .tex_valid(tex_valid), .tex_rgb(tex_rgb),
    .tex_alpha(tex_alpha), .tex_stipple_idx(tex_stipple_idx), .depth_fail(depth_fail),
    .swap_now(swap_now), .swaps_pending(swaps_pending), .fog_colour_out(fog_colour_out),
    .local_colour(local_colour), .local_alpha(local_alpha), .other_colour(other_colour),
    .other_colour_sel(other_colour_sel), .other_alpha(other_alpha),
    .other_alpha_sel(other_alpha_sel), .fill_colour(fill_colour), .fill_depth(fill_depth),
    .bias_depth(bias_depth), .lfb_alpha(lfb_alpha), .lfb_depth(lfb_depth),
    .lfb_colour(lfb_colour), .lfb_colour_sel(lfb_colour_sel), .px_valid(px_valid),
    .px_rgb(px_rgb), .px_alpha(px_alpha), .px_key_drop(px_key_drop),
    .px_colour_wr(px_colour_wr), .px_depth_wr(px_depth_wr));

  // ********
  // helpers
  // ********

  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    samples_checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask : chk

  // read with exactly one answer
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    fbr_host_i.rd(a, rd_d, rd_v);
    chk(32'(rd_v), 32'h1, "read answer");
    chk(rd_d, exp, "read data");
  endtask : rdchk

  // inputs change one time unit after the edge
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : cyc

  // one-cycle event pulses: retrace, walker pixel, depth failure
  task automatic strobe(input logic r, input logic w, input logic d);
    vretrace_pulse = r;
    walk_pixel = w;
    depth_fail = d;
    cyc(1);
    vretrace_pulse = 1'b0;
    walk_pixel = 1'b0;
    depth_fail = 1'b0;
  endtask : strobe

  // swap pulse lasts one cycle, so every cycle is looked at
  task automatic wait_swap(input int n, input logic exp);
    seen = (swap_now === 1'b1); // a pulse launched at the strobe's edge stands now
    repeat (n)
    begin
      cyc(1);
      if (swap_now === 1'b1)
        seen = 1'b1;
    end
    chk(32'(seen), 32'(exp), "swap pulse");
  endtask : wait_swap

  // one textured pixel, results stand in the next cycle
  task automatic pix(input logic [23:0] c, input logic [4:0] i, input logic [2:0] e);
    tex_valid = 1'b1;
    tex_rgb = c;
    tex_alpha = 8'haa;
    tex_stipple_idx = i;
    cyc(1);
    tex_valid = 1'b0;
    tex_rgb = ~c;
    chk({px_rgb, px_alpha}, {c, 8'haa}, "pixel passthrough");
    chk(32'({px_valid, px_key_drop, px_colour_wr, px_depth_wr}), 32'({1'b1, e}), "pixel flags");
    // idle cycle so the next pixel never re-raises valid in this time step
    cyc(1);
  endtask : pix

  // closing
  task automatic stop_test();
    $display("checked %0d, wrong %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : stop_test

  // watchdog, far beyond the 140 or so cycles the tests need
  initial
  begin
    #100000;
    n_fail++;
    stop_test();
  end

  // ********
  // tests
  // ********
  initial
  begin
    {vretrace_pulse, fog_en, chroma_en, depth_bias_en, lfb_pipe_en} = 5'h00;
    {walk_pixel, tex_valid, depth_fail} = 3'h0;
    colour_path_sel = 4'h0;
    lfb_format = 4'h0;
    tex_rgb = 24'h00_0000;
    tex_alpha = 8'h00;
    tex_stipple_idx = 5'h00;
    cyc(6);
    rst = 1'b0;
    fbr_host_i.wr(8'h0c, 32'hffff_ffff);
    for (int i = 0; i < 13; i++)
      rdchk(8'(i), 32'h0);
    $display("test reset done");

    fbr_host_i.wr(IDX_FOG, 32'hd1a2_b3c4);
    cyc(2);
    chk(32'(fog_colour_out), 32'h0, "fog off");
    fog_en = 1'b1;
    cyc(2);
    chk(32'(fog_colour_out), 32'ha2_b3c4, "fog colour");
    rdchk(IDX_FOG, 32'hd1a2_b3c4);
    fbr_host_i.wr(IDX_ZA, 32'h5e00_9a7b);
    cyc(2);
    chk(32'(bias_depth), 32'h0, "bias off");
    depth_bias_en = 1'b1;
    cyc(2);
    chk(32'(fill_depth), 32'h9a7b, "fill depth");
    chk(32'(bias_depth), 32'h9a7b, "bias depth");
    chk({lfb_alpha, 8'h00, lfb_depth}, 32'h5e00_9a7b, "linear subst");
    fbr_host_i.wr(IDX_KEY, 32'hff13_2435);
    rdchk(IDX_KEY, 32'h0013_2435);
    fbr_host_i.wr(IDX_STIP, 32'h8000_0001);
    rdchk(IDX_STIP, 32'h8000_0001);
    fbr_host_i.wr(IDX_C0, 32'h7f44_5566);
    fbr_host_i.wr(IDX_C1, 32'h3c77_8899);
    colour_path_sel = 4'ha;
    lfb_pipe_en = 1'b1;
    lfb_format = 4'hf;
    cyc(2);
    chk({local_alpha, local_colour}, 32'h7f44_5566, "local");
    chk({other_alpha, other_colour}, 32'h3c77_8899, "other");
    chk(32'({other_colour_sel, other_alpha_sel}), 32'h3, "other sel");
    chk(32'(fill_colour), 32'h77_8899, "fill colour");
    chk({7'h0, lfb_colour_sel, lfb_colour}, 32'h0177_8899, "linear colour");
    colour_path_sel = 4'h5;
    lfb_format = 4'he;
    cyc(2);
    chk(32'({other_colour_sel, other_alpha_sel, lfb_colour_sel}), 32'h0, "sel off");
    rdchk(IDX_C0, 32'h7f44_5566);
    $display("test constants done");

    chroma_en = 1'b1;
    pix(24'h13_2435, 5'd0, 3'b101);
    pix(24'h13_2436, 5'd1, 3'b000);
    pix(24'h13_2436, 5'd31, 3'b011);
    chroma_en = 1'b0;
    cyc(2);
    pix(24'h13_2435, 5'd0, 3'b011);
    rdchk(IDX_KEYF, 32'h1);
    $display("test keying done");

    // back-to-back pulses held as levels: four walker pixels, three depth failures
    walk_pixel = 1'b1;
    cyc(3);
    walk_pixel = 1'b0;
    depth_fail = 1'b1;
    cyc(2);
    walk_pixel = 1'b1;
    cyc(1);
    walk_pixel = 1'b0;
    depth_fail = 1'b0;
    cyc(1);
    rdchk(IDX_PIXIN, 32'h4);
    rdchk(IDX_ZF, 32'h3);
    fbr_host_i.wr(IDX_FLUSH, 32'hffff_fffe);
    rdchk(IDX_PIXIN, 32'h4);
    rdchk(IDX_KEYF, 32'h1);
    fbr_host_i.wr(IDX_FLUSH, 32'h0000_0001);
    for (int i = 9; i < 12; i++)
      rdchk(8'(i), 32'h0);
    $display("test counters done");

    fbr_host_i.wr(IDX_SWAP, 32'h0000_000a);
    wait_swap(4, 1'b1);
    cyc(1);
    chk(32'(swaps_pending), 32'h0, "pending");
    fbr_host_i.wr(IDX_SWAP, 32'h0000_0005);
    wait_swap(3, 1'b0);
    chk(32'(swaps_pending), 32'h1, "pending");
    rdchk(IDX_STATUS, 32'h1000_0000);
    repeat (2)
    begin
      strobe(1'b1, 1'b0, 1'b0);
      wait_swap(2, 1'b0);
    end
    strobe(1'b1, 1'b0, 1'b0);
    wait_swap(2, 1'b1);
    fbr_host_i.swap_triple();
    fbr_host_i.swap_triple();
    cyc(2);
    chk(32'(swaps_pending), 32'h2, "pending");
    repeat (2)
    begin
      strobe(1'b1, 1'b0, 1'b0);
      wait_swap(2, 1'b1);
    end
    cyc(1);
    chk(32'(swaps_pending), 32'h0, "pending");
    $display("test swap done");
    stop_test();
  end
endmodule : fbr_regs_test
